/* File: inc/sic_params.svh */
// Offsets, field positions, codes and timing counts of the scan-interval counter block
`ifndef SIC_PARAMS_SVH
`define SIC_PARAMS_SVH

`define SIC_ADDR_CMD 32'h0000_0000
`define SIC_ADDR_DATA 32'h0000_0004
`define SIC_ADDR_CTRL 32'h0000_0008
`define SIC_ADDR_STATUS 32'h0000_000c

`define SIC_RESP_OKAY 2'h0
`define SIC_RESP_SLVERR 2'h2

`define SIC_CMD_C2_DISARM 16'hffb2
`define SIC_CMD_C2_SEL_MODE 16'hff02
`define SIC_CMD_C2_SEL_LOAD 16'hff0a
`define SIC_CMD_C2_SEL_HOLD 16'hff12
`define SIC_CMD_C2_LOAD 16'hff42
`define SIC_CMD_C2_CLR_OUT 16'hffe2
`define SIC_CMD_C2_ARM 16'hff22
`define SIC_CMD_C3_SEL_MODE 16'hff03
`define SIC_CMD_C3_SEL_LOAD 16'hff0b
`define SIC_CMD_C3_LOAD_ARM 16'hff64
`define SIC_CMD_C1_SEL_MODE 16'hff01
`define SIC_CMD_C1_SEL_LOAD 16'hff09
`define SIC_CMD_C1_LOAD 16'hff41
`define SIC_CMD_C1_STEP 16'hfff1
`define SIC_CMD_C1_ARM 16'hff21

`define SIC_MODE_C2_HIZ 16'h0004
`define SIC_SRC_LSB 8
`define SIC_SRC_EXT 4'h5
`define SIC_SRC_1MHZ 4'hb
`define SIC_SRC_100HZ 4'hf

`define SIC_CTRL_DIV_BIT 0
`define SIC_CTRL_BASIC_BIT 1
`define SIC_CTRL_WIDE_BIT 2
`define SIC_CTRL_LEN_LSB 16
`define SIC_CTRL_MASK 32'h01ff_0007
`define SIC_CTRL_RST 32'h0000_0000

`define SIC_STAT_C1_ARMED_BIT 0
`define SIC_STAT_C2_ARMED_BIT 1
`define SIC_STAT_C3_ARMED_BIT 2
`define SIC_STAT_HOLD_BIT 3
`define SIC_STAT_FLOAT_BIT 4
`define SIC_STAT_SRC_DIFF_BIT 5
`define SIC_STAT_IDX_LSB 16

`define SIC_LIST_SMALL 16
`define SIC_LIST_LARGE 512

`define SIC_CLK_HZ 50000000
`define SIC_TB_FAST_HZ 1000000
`define SIC_TB_CYCLES (`SIC_CLK_HZ / `SIC_TB_FAST_HZ)
`define SIC_TB_DECADE 10
`define SIC_TB_COUNT 5

`endif

/* File: inc/sic_pkg.sv */
// Types shared by the scan-interval counter block
package sic_pkg;

	typedef struct packed {
		logic [31:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [31:0] araddr;
		logic arvalid;
		logic rready;
	} sic_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sic_axi_rsp_t;

	typedef enum logic [2:0] {
		SIC_SEL_NONE, SIC_SEL_C1_MODE, SIC_SEL_C1_LOAD, SIC_SEL_C2_MODE,
		SIC_SEL_C2_LOAD, SIC_SEL_C2_HOLD, SIC_SEL_C3_MODE, SIC_SEL_C3_LOAD
	} sic_sel_t;

	typedef struct packed {
		logic [15:0] mode;
		logic [15:0] load;
		logic [15:0] hold;
		logic [16:0] count;
		logic armed;
		logic out;
	} sic_ctr_t;

	typedef struct packed {
		logic meta;
		logic level;
		logic prev;
		logic rise;
	} sic_sync_t;

	typedef struct packed {
		logic [15:0] pre;
		logic [4:0][3:0] dec;
		logic [4:0] tick;
	} sic_tb_t;

	typedef struct packed {
		sic_ctr_t c1;
		sic_ctr_t c2;
		sic_ctr_t c3;
		sic_sel_t sel;
		logic [15:0] last_cmd;
		logic [31:0] ctrl;
		logic aw_have;
		logic w_have;
		logic [31:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		sic_axi_rsp_t rsp;
		logic [8:0] idx;
		logic hold_trig;
		logic pin_oe;
		logic strobe;
		logic div_pulse;
		logic adv;
	} sic_state_t;

endpackage : sic_pkg

/* File: rtl/sic_edge_sync.sv */
// Two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ns
module sic_edge_sync (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic async_in,
	output logic level,
	output logic rise
);
	sic_pkg::sic_sync_t q;
	sic_pkg::sic_sync_t d;

	always_comb begin
		d = q;
		d.meta = async_in;
		d.level = q.meta;
		d.prev = q.level;
		d.rise = q.level && !q.prev;
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level = q.level;
	assign rise = q.rise;
endmodule : sic_edge_sync

/* File: rtl/sic_scan_counter.sv */
// Scan-interval, sample-interval and divider counters with AXI4-Lite command/data access
//
// How it works
// RULE1 - Scan counter square wave: high phase, full period
// RULE2 - Software uses same timebase on both counters
// RULE3 - Basic variant runs track/hold level-sensitive
// RULE4 - Software computes high and low counts
// RULE5 - Command ffb2 disarms scan counter
// RULE6 - Command ff02 points data at scan mode
// RULE7 - Scan mode high byte picks timebase or external
// RULE8 - Command ff0a selects low-phase load register
// RULE9 - Command ff12 selects high-phase hold register
// RULE10 - ff42 loads, ffe2 clears output, ff22 arms
// RULE11 - ff03 selects sample mode; timebase choice likewise
// RULE12 - Software writes the interval count after ff0b
// RULE13 - Command ff64 loads and arms sample counter
// RULE14 - Interval 65536 is written as zero
// RULE15 - Scan mode 0004 floats output, not basic
// RULE16 - External hold trigger must space its pulses
// RULE17 - One or N samples per scan entry
// RULE18 - ff01 mode, ff09 then count for divider
// RULE19 - ff41 load, fff1 step, ff21 arm divider
// RULE20 - Scan-divide bit makes divider pace entries
// RULE21 - Scan list holds 16 or 512 entries
// RULE22 - Interval programming drives strobe and hold trigger
// RULE23 - Scan counter alternates hold and load counts
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "sic_params.svh"
module sic_scan_counter #(
	parameter int CYC_PER_TICK = `SIC_TB_CYCLES,
	parameter int LIST_SMALL = `SIC_LIST_SMALL,
	parameter int LIST_LARGE = `SIC_LIST_LARGE
) (
	input wire logic ref_clk,
	input wire logic srst,
	input sic_pkg::sic_axi_req_t axi_req,
	output sic_pkg::sic_axi_rsp_t axi_rsp,
	input wire logic external_source_five,
	input wire logic counter_two_output_i,
	output logic counter_two_output_o,
	output logic counter_two_output_oe,
	output logic hold_trigger,
	output logic sample_strobe,
	output logic scan_advance,
	output logic [8:0] scan_entry_index,
	output logic track_hold_level_mode
);
	sic_pkg::sic_state_t q;
	sic_pkg::sic_state_t d;
	logic [4:0] tb_tick;
	logic ext_rise;
	logic pin_level;

	if (LIST_SMALL < 2 || LIST_SMALL > LIST_LARGE) begin : g_chk_small
		$error("Short scan list size unsupported");
	end
	// Entry index is nine bits wide
	if (LIST_LARGE > 512) begin : g_chk_large
		$error("Long scan list exceeds the index width");
	end
	if (CYC_PER_TICK < 1 || CYC_PER_TICK > 65535) begin : g_chk_tick
		$error("Timebase divider out of range");
	end

	sic_timebase #(
		.CYC_PER_TICK(CYC_PER_TICK)
	) u_tb (
		.ref_clk(ref_clk),
		.srst(srst),
		.tick(tb_tick)
	);

	// Source edges arrive three cycles late after synchronising
	sic_edge_sync u_src5 (
		.ref_clk(ref_clk),
		.srst(srst),
		.async_in(external_source_five),
		.level(),
		.rise(ext_rise)
	);

	// External hold trigger seen on the pin while the counter floats
	sic_edge_sync u_pin (
		.ref_clk(ref_clk),
		.srst(srst),
		.async_in(counter_two_output_i),
		.level(pin_level),
		.rise()
	);

	// Counting source chosen by the high byte of a mode word
	function automatic logic src_tick(input logic [15:0] mode, input logic [4:0] tk, input logic ext);
		logic [3:0] src;
		src = mode[`SIC_SRC_LSB +: 4];
		if (src == `SIC_SRC_EXT) begin
			return ext; // RULE7
		end else if (src >= `SIC_SRC_1MHZ && src <= `SIC_SRC_100HZ) begin
			return tk[3'(src - `SIC_SRC_1MHZ)]; // RULE7
		end
		return 1'b0;
	endfunction : src_tick

	// Zero stands for a full 65536 count
	function automatic logic [16:0] reload(input logic [15:0] v);
		return (v == 16'h0000) ? 17'h10000 : {1'b0, v}; // RULE14
	endfunction : reload

	function automatic logic [31:0] rd_word(input sic_pkg::sic_state_t s);
		logic [15:0] v;
		v = 16'h0000;
		case (s.sel)
			sic_pkg::SIC_SEL_C1_MODE: v = s.c1.mode;
			sic_pkg::SIC_SEL_C1_LOAD: v = s.c1.load;
			sic_pkg::SIC_SEL_C2_MODE: v = s.c2.mode;
			sic_pkg::SIC_SEL_C2_LOAD: v = s.c2.load;
			sic_pkg::SIC_SEL_C2_HOLD: v = s.c2.hold;
			sic_pkg::SIC_SEL_C3_MODE: v = s.c3.mode;
			sic_pkg::SIC_SEL_C3_LOAD: v = s.c3.load;
			default: v = 16'h0000;
		endcase
		return {16'h0000, v};
	endfunction : rd_word

	// Status flags in the low bits, entry index in the upper half
	function automatic logic [31:0] status_word(input sic_pkg::sic_state_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`SIC_STAT_C1_ARMED_BIT] = s.c1.armed;
		w[`SIC_STAT_C2_ARMED_BIT] = s.c2.armed;
		w[`SIC_STAT_C3_ARMED_BIT] = s.c3.armed;
		w[`SIC_STAT_HOLD_BIT] = s.hold_trig;
		w[`SIC_STAT_FLOAT_BIT] = !s.pin_oe;
		// Flags a scan/sample timebase mismatch, which software must avoid
		w[`SIC_STAT_SRC_DIFF_BIT] = s.c2.mode[`SIC_SRC_LSB +: 4] != s.c3.mode[`SIC_SRC_LSB +: 4]; // RULE2
		w[`SIC_STAT_IDX_LSB +: 9] = s.idx;
		return w;
	endfunction : status_word

	always_comb begin
		logic c2_hiz;
		logic entry_pulse;
		logic [8:0] last_idx;
		logic [8:0] max_idx;
		logic [15:0] cmd;
		logic [15:0] dval;
		logic [31:0] merged;
		logic c2_tick;
		logic c3_tick;
		logic lanes_lo;
		c2_hiz = 1'b0;
		entry_pulse = 1'b0;
		last_idx = '0;
		max_idx = '0;
		cmd = q.wdata[15:0];
		dval = q.wdata[15:0];
		merged = q.ctrl;
		// One source decode, so matching modes tick on the same cycle
		c2_tick = src_tick(q.c2.mode, tb_tick, ext_rise); // RULE7
		c3_tick = src_tick(q.c3.mode, tb_tick, ext_rise); // RULE11
		// Command and data words need both low byte lanes
		lanes_lo = &q.wstrb[1:0];
		d = q;
		d.strobe = 1'b0;
		d.div_pulse = 1'b0;
		d.adv = 1'b0;

		// Scan counter: high phase counts hold, low phase counts load
		// A count of one or less is terminal, so a zero left by reset toggles at once
		if (q.c2.armed && c2_tick) begin
			if (q.c2.count <= 17'h00001) begin
				d.c2.out = !q.c2.out; // RULE1
				d.c2.count = q.c2.out ? {1'b0, q.c2.load} : {1'b0, q.c2.hold}; // RULE23
			end else begin
				d.c2.count = q.c2.count - 17'h00001;
			end
		end

		// Sample counter: one strobe per interval, reloads continuously
		if (q.c3.armed && c3_tick) begin
			if (q.c3.count <= 17'h00001) begin
				d.strobe = 1'b1; // RULE22
				d.c3.count = reload(q.c3.load);
			end else begin
				d.c3.count = q.c3.count - 17'h00001;
			end
		end

		// Divider counts sample strobes
		if (q.c1.armed && d.strobe) begin
			if (q.c1.count <= 17'h00001) begin
				d.div_pulse = 1'b1; // RULE17
				d.c1.count = reload(q.c1.load);
			end else begin
				d.c1.count = q.c1.count - 17'h00001;
			end
		end

		// Scan list advance
		entry_pulse = q.ctrl[`SIC_CTRL_DIV_BIT] ? d.div_pulse : d.strobe; // RULE20
		max_idx = q.ctrl[`SIC_CTRL_WIDE_BIT] ? 9'(LIST_LARGE - 1) : 9'(LIST_SMALL - 1); // RULE21
		last_idx = q.ctrl[`SIC_CTRL_LEN_LSB +: 9];
		if (last_idx > max_idx) begin
			last_idx = max_idx; // RULE21
		end
		if (entry_pulse) begin
			d.adv = 1'b1;
			d.idx = (q.idx >= last_idx) ? 9'h000 : q.idx + 9'h001; // RULE17
		end

		// Write channel capture, either order
		if (q.rsp.awready && axi_req.awvalid) begin
			d.aw_have = 1'b1;
			d.awaddr = axi_req.awaddr;
		end
		if (q.rsp.wready && axi_req.wvalid) begin
			d.w_have = 1'b1;
			d.wdata = axi_req.wdata;
			d.wstrb = axi_req.wstrb;
		end
		if (q.rsp.bvalid && axi_req.bready) begin
			d.rsp.bvalid = 1'b0;
		end

		// Commands and data act after counting, so a command wins its cycle
		if (q.aw_have && q.w_have && !q.rsp.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp = `SIC_RESP_OKAY;
			case (q.awaddr)
				`SIC_ADDR_CMD: begin
					// Half-word commands only take effect when both low lanes are written
					if (lanes_lo) begin
						d.last_cmd = cmd;
						case (cmd)
							`SIC_CMD_C2_DISARM: d.c2.armed = 1'b0; // RULE5
							`SIC_CMD_C2_SEL_MODE: d.sel = sic_pkg::SIC_SEL_C2_MODE; // RULE6
							`SIC_CMD_C2_SEL_LOAD: d.sel = sic_pkg::SIC_SEL_C2_LOAD; // RULE8
							`SIC_CMD_C2_SEL_HOLD: d.sel = sic_pkg::SIC_SEL_C2_HOLD; // RULE9
							`SIC_CMD_C2_LOAD: d.c2.count = q.c2.out ? {1'b0, q.c2.hold} : {1'b0, q.c2.load}; // RULE10
							`SIC_CMD_C2_CLR_OUT: d.c2.out = 1'b0; // RULE10
							`SIC_CMD_C2_ARM: d.c2.armed = 1'b1; // RULE10
							`SIC_CMD_C3_SEL_MODE: d.sel = sic_pkg::SIC_SEL_C3_MODE; // RULE11
							`SIC_CMD_C3_SEL_LOAD: d.sel = sic_pkg::SIC_SEL_C3_LOAD; // RULE12
							`SIC_CMD_C3_LOAD_ARM: begin
								d.c3.count = reload(q.c3.load); // RULE13
								d.c3.armed = 1'b1; // RULE13
							end
							`SIC_CMD_C1_SEL_MODE: d.sel = sic_pkg::SIC_SEL_C1_MODE; // RULE18
							`SIC_CMD_C1_SEL_LOAD: d.sel = sic_pkg::SIC_SEL_C1_LOAD; // RULE18
							`SIC_CMD_C1_LOAD: d.c1.count = reload(q.c1.load); // RULE19
							`SIC_CMD_C1_STEP: begin
								if (q.c1.count <= 17'h00001) begin
									d.c1.count = reload(q.c1.load); // RULE19
								end else begin
									d.c1.count = q.c1.count - 17'h00001; // RULE19
								end
							end
							`SIC_CMD_C1_ARM: d.c1.armed = 1'b1; // RULE19
							default: d.last_cmd = cmd;
						endcase
					end
				end
				`SIC_ADDR_DATA: begin
					if (lanes_lo) begin
						case (q.sel)
							sic_pkg::SIC_SEL_C1_MODE: d.c1.mode = dval; // RULE18
							sic_pkg::SIC_SEL_C1_LOAD: d.c1.load = dval; // RULE18
							sic_pkg::SIC_SEL_C2_MODE: d.c2.mode = dval; // RULE7
							sic_pkg::SIC_SEL_C2_LOAD: d.c2.load = dval; // RULE8
							sic_pkg::SIC_SEL_C2_HOLD: d.c2.hold = dval; // RULE9
							sic_pkg::SIC_SEL_C3_MODE: d.c3.mode = dval; // RULE11
							sic_pkg::SIC_SEL_C3_LOAD: d.c3.load = dval; // RULE14
							default: d.sel = q.sel;
						endcase
					end
				end
				`SIC_ADDR_CTRL: begin
					for (int b = 0; b < 4; b++) begin
						if (q.wstrb[b]) begin
							merged[8*b +: 8] = q.wdata[8*b +: 8];
						end
					end
					d.ctrl = merged & `SIC_CTRL_MASK;
				end
				`SIC_ADDR_STATUS: begin
					// Read-only: the write is answered and dropped
					d.rsp.bresp = `SIC_RESP_OKAY;
				end
				default: d.rsp.bresp = `SIC_RESP_SLVERR;
			endcase
		end

		// Read channel
		if (q.rsp.rvalid && axi_req.rready) begin
			d.rsp.rvalid = 1'b0;
		end
		if (q.rsp.arready && axi_req.arvalid) begin
			d.rsp.rvalid = 1'b1;
			d.rsp.rresp = `SIC_RESP_OKAY;
			case (axi_req.araddr)
				`SIC_ADDR_CMD: d.rsp.rdata = {16'h0000, q.last_cmd};
				`SIC_ADDR_DATA: d.rsp.rdata = rd_word(q);
				`SIC_ADDR_CTRL: d.rsp.rdata = q.ctrl;
				`SIC_ADDR_STATUS: d.rsp.rdata = status_word(q);
				default: begin
					d.rsp.rdata = 32'h0000_0000;
					d.rsp.rresp = `SIC_RESP_SLVERR;
				end
			endcase
		end

		// Readies fall while a word is held or its answer waits: one write at a time
		d.rsp.awready = !d.aw_have && !d.rsp.bvalid;
		d.rsp.wready = !d.w_have && !d.rsp.bvalid;
		d.rsp.arready = !d.rsp.rvalid;

		// Floating output, refused on the basic variant
		c2_hiz = (d.c2.mode == `SIC_MODE_C2_HIZ) && !d.ctrl[`SIC_CTRL_BASIC_BIT]; // RULE15
		d.pin_oe = !c2_hiz; // RULE15
		// Pin level is used only when the counter floats
		d.hold_trig = c2_hiz ? pin_level : d.c2.out; // RULE22
	end

	// Synchronous reset clears every register, outputs included
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Every output comes straight from a register
	assign axi_rsp = q.rsp;
	assign counter_two_output_o = q.c2.out;
	assign counter_two_output_oe = q.pin_oe;
	assign hold_trigger = q.hold_trig;
	assign sample_strobe = q.strobe;
	assign scan_advance = q.adv;
	assign scan_entry_index = q.idx;
	assign track_hold_level_mode = q.ctrl[`SIC_CTRL_BASIC_BIT]; // RULE3
endmodule : sic_scan_counter

/* File: rtl/sic_timebase.sv */
// Decade timebase ticks: 1 MHz, 100 kHz, 10 kHz, 1 kHz, 100 Hz
`timescale 1ns/1ns
`include "sic_params.svh"
module sic_timebase #(
	parameter int CYC_PER_TICK = `SIC_TB_CYCLES
) (
	input wire logic ref_clk,
	input wire logic srst,
	output logic [4:0] tick
);
	sic_pkg::sic_tb_t q;
	sic_pkg::sic_tb_t d;

	if (CYC_PER_TICK < 1 || CYC_PER_TICK > 65535) begin : g_chk
		$error("CYC_PER_TICK out of range");
	end

	always_comb begin
		logic carry;
		carry = 1'b0;
		d = q;
		d.tick = '0;
		if (q.pre >= 16'(CYC_PER_TICK - 1)) begin
			d.pre = '0;
			carry = 1'b1;
		end else begin
			d.pre = q.pre + 16'h0001;
		end
		d.tick[0] = carry;
		// Each slower tick lands on the same cycle as the faster one
		for (int i = 1; i < `SIC_TB_COUNT; i++) begin
			if (carry) begin
				if (q.dec[i] >= 4'(`SIC_TB_DECADE - 1)) begin
					d.dec[i] = '0;
				end else begin
					d.dec[i] = q.dec[i] + 4'h1;
					carry = 1'b0;
				end
			end
			d.tick[i] = carry;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick = q.tick;
endmodule : sic_timebase

/* File: test/sic_scan_counter_assertions.sv */
// Port-level checks for the scan-interval counter block
`timescale 1ns/1ns
module sic_scan_counter_assertions #(
	parameter int CYC_PER_TICK = 50,
	parameter int LIST_SMALL = 16,
	parameter int LIST_LARGE = 512
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire sic_pkg::sic_axi_req_t axi_req,
	input wire sic_pkg::sic_axi_rsp_t axi_rsp,
	input wire logic external_source_five,
	input wire logic counter_two_output_i,
	input wire logic counter_two_output_o,
	input wire logic counter_two_output_oe,
	input wire logic hold_trigger,
	input wire logic sample_strobe,
	input wire logic scan_advance,
	input wire logic [8:0] scan_entry_index,
	input wire logic track_hold_level_mode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence s_wr_taken;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence
	sequence s_rd_taken;
		axi_req.arvalid && axi_rsp.arready;
	endsequence

	AST_B_ANSWER: assert property (s_wr_taken |-> ##2 axi_rsp.bvalid)
		else $error("write response late");
	AST_B_STANDS: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
		else $error("write response dropped");
	AST_R_ANSWER: assert property (s_rd_taken |=> axi_rsp.rvalid)
		else $error("read data late");
	AST_R_STANDS: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read data dropped");
	AST_W_BLOCKED: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
		else $error("second write accepted");
	AST_R_BLOCKED: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
		else $error("second read accepted");
	AST_FLOAT_BASIC: assert property (!counter_two_output_oe |-> !track_hold_level_mode)
		else $error("pin floats on basic variant");
	AST_SQUARE_HIGH: assert property ($rose(counter_two_output_o) |=> counter_two_output_o)
		else $error("scan output high phase too short");
	AST_STROBE_PULSE: assert property (sample_strobe |=> !sample_strobe)
		else $error("sample strobe not a pulse");
	AST_ADV_PULSE: assert property (scan_advance |=> !scan_advance)
		else $error("scan advance not a pulse");
endmodule : sic_scan_counter_assertions

bind sic_scan_counter sic_scan_counter_assertions #(.CYC_PER_TICK(CYC_PER_TICK), .LIST_SMALL(LIST_SMALL),
	.LIST_LARGE(LIST_LARGE)) u_chk (.ref_clk(ref_clk), .srst(srst), .axi_req(axi_req), .axi_rsp(axi_rsp),
	.external_source_five(external_source_five), .counter_two_output_i(counter_two_output_i),
	.counter_two_output_o(counter_two_output_o), .counter_two_output_oe(counter_two_output_oe),
	.hold_trigger(hold_trigger), .sample_strobe(sample_strobe), .scan_advance(scan_advance),
	.scan_entry_index(scan_entry_index), .track_hold_level_mode(track_hold_level_mode));

/* File: test/tb.sv */
// Self-checking bench for the scan-interval counter block
`timescale 1ns/1ns
`include "sic_params.svh"
module tb;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	sic_pkg::sic_axi_req_t req = '0;
	sic_pkg::sic_axi_rsp_t rsp;
	logic ext = 1'b0;
	logic [1:0] ext_div = 2'h0;
	logic pin_i = 1'b0;
	logic o, oe, ht, stb, adv, thl;
	logic [8:0] idx;
	logic [1:0] rs;
	logic [31:0] rv;
	int errors = 0;
	int check_count = 0;
	// Slow modes come first so the last one left armed toggles fast
	logic [15:0] modes [6] = '{16'h4d62, 16'h4e62, 16'h4f62, 16'h4c62, 16'h4562, 16'h4b62};
	int per [6] = '{0, 0, 0, 20, 4, 2};

	always #10 ref_clk = ~ref_clk;
	// External source: one rising edge every 4 clocks
	always @(posedge ref_clk) begin
		ext_div <= ext_div + 2'h1;
		ext <= ext_div[1];
	end

	sic_scan_counter #(.CYC_PER_TICK(2)) u_dut (.ref_clk(ref_clk), .srst(srst), .axi_req(req), .axi_rsp(rsp),
		.external_source_five(ext), .counter_two_output_i(pin_i), .counter_two_output_o(o),
		.counter_two_output_oe(oe), .hold_trigger(ht), .sample_strobe(stb), .scan_advance(adv),
		.scan_entry_index(idx), .track_hold_level_mode(thl));

	task automatic test_done();
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		req.awaddr <= a;
		req.awvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (rsp.awready === 1'b1)
				req.awvalid <= 1'b0;
			if (rsp.wready === 1'b1)
				req.wvalid <= 1'b0;
			if (rsp.bvalid === 1'b1) begin
				r = rsp.bresp;
				req.bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (rsp.arready === 1'b1)
				req.arvalid <= 1'b0;
			if (rsp.rvalid === 1'b1) begin
				d = rsp.rdata;
				r = rsp.rresp;
				req.rready <= 1'b0;
				break;
			end
		end
	endtask : rd

	task automatic cmd(input logic [15:0] c);
		wr(`SIC_ADDR_CMD, {16'h0, c}, rs);
	endtask : cmd

	task automatic dat(input logic [15:0] v);
		wr(`SIC_ADDR_DATA, {16'h0, v}, rs);
	endtask : dat

	// Skips the partial phase, then times one high and one low phase
	task automatic meas(output int hi, output int lo);
		hi = 0;
		lo = 0;
		@(posedge ref_clk);
		while (o !== 1'b0) @(posedge ref_clk);
		while (o !== 1'b1) @(posedge ref_clk);
		while (o === 1'b1) begin
			@(posedge ref_clk);
			hi++;
		end
		while (o === 1'b0) begin
			@(posedge ref_clk);
			lo++;
		end
	endtask : meas

	task automatic watch(input int n, output int ns, output int na, output logic [8:0] mx);
		ns = 0;
		na = 0;
		mx = 9'h0;
		repeat (n) begin
			@(posedge ref_clk);
			ns += int'(stb === 1'b1);
			na += int'(adv === 1'b1);
			if (idx > mx)
				mx = idx;
		end
	endtask : watch

	initial begin
		repeat (50000) @(posedge ref_clk);
		errors++;
		test_done();
	end

	initial begin
		int hi, lo, ns, na;
		logic [8:0] mx;
		logic keep;
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		rd(`SIC_ADDR_CTRL, rv, rs);
		chk(rv, `SIC_CTRL_RST);
		rd(`SIC_ADDR_STATUS, rv, rs);
		chk(rv, 32'h0);
		rd(32'h0000_0010, rv, rs);
		chk({rv[29:0], rs}, {30'h0, `SIC_RESP_SLVERR});
		wr(32'h0000_0010, 32'h0000_ffff, rs);
		chk(32'(rs), 32'(`SIC_RESP_SLVERR));
		for (int i = 0; i < 6; i++) begin
			cmd(`SIC_CMD_C2_DISARM);
			cmd(`SIC_CMD_C2_SEL_MODE);
			dat(modes[i]);
			rd(`SIC_ADDR_DATA, rv, rs);
			chk(rv, {16'h0, modes[i]});
			cmd(`SIC_CMD_C2_SEL_LOAD);
			dat(16'h0002);
			cmd(`SIC_CMD_C2_SEL_HOLD);
			dat(16'h0003);
			rd(`SIC_ADDR_DATA, rv, rs);
			chk(rv, 32'h0000_0003);
			cmd(`SIC_CMD_C2_LOAD);
			cmd(`SIC_CMD_C2_CLR_OUT);
			chk(32'(o), 32'h0);
			chk(32'(ht), 32'h0);
			cmd(`SIC_CMD_C2_ARM);
			if (per[i] > 0) begin
				meas(hi, lo);
				chk(32'(hi), 32'(3 * per[i]));
				chk(32'(lo), 32'(2 * per[i]));
			end
		end
		cmd(`SIC_CMD_C2_DISARM);
		keep = o;
		repeat (50) @(posedge ref_clk);
		chk(32'(o), 32'(keep));
		cmd(`SIC_CMD_C3_SEL_MODE);
		dat(16'h4b25);
		cmd(`SIC_CMD_C3_SEL_LOAD);
		dat(16'h0001);
		cmd(`SIC_CMD_C3_LOAD_ARM);
		dat(16'h0002);
		rd(`SIC_ADDR_STATUS, rv, rs);
		chk({30'h0, rv[5], rv[2]}, 32'h1);
		chk(32'(rv[5]), 32'h0);
		while (stb !== 1'b1) @(posedge ref_clk);
		ns = 0;
		do begin
			@(posedge ref_clk);
			ns++;
		end while (stb !== 1'b1);
		chk(32'(ns), 32'h4);
		cmd(`SIC_CMD_C2_SEL_MODE);
		dat(`SIC_MODE_C2_HIZ);
		chk(32'(oe), 32'h0);
		@(posedge ref_clk);
		pin_i <= 1'b1;
		repeat (5) @(posedge ref_clk);
		chk(32'(ht), 32'h1);
		pin_i <= 1'b0;
		repeat (5) @(posedge ref_clk);
		chk(32'(ht), 32'h0);
		dat(16'h4b62);
		wr(`SIC_ADDR_CTRL, 32'h0000_0002, rs);
		chk(32'(thl), 32'h1);
		dat(`SIC_MODE_C2_HIZ);
		chk(32'(oe), 32'h1);
		wr(`SIC_ADDR_CTRL, 32'h0014_0000, rs);
		watch(200, ns, na, mx);
		chk(32'(na >= ns - 1 && na <= ns + 1), 32'h1);
		chk(32'(mx), 32'(`SIC_LIST_SMALL - 1));
		wr(`SIC_ADDR_CTRL, 32'h0014_0004, rs);
		watch(200, ns, na, mx);
		chk(32'(mx), 32'h14);
		cmd(`SIC_CMD_C1_SEL_MODE);
		dat(16'h1325);
		rd(`SIC_ADDR_DATA, rv, rs);
		chk(rv, 32'h0000_1325);
		dat(16'h0325);
		cmd(`SIC_CMD_C1_SEL_LOAD);
		dat(16'h0003);
		cmd(`SIC_CMD_C1_LOAD);
		cmd(`SIC_CMD_C1_STEP);
		cmd(`SIC_CMD_C1_ARM);
		wr(`SIC_ADDR_CTRL, 32'h0014_0005, rs);
		rd(`SIC_ADDR_STATUS, rv, rs);
		chk(32'(rv[0]), 32'h1);
		while (adv !== 1'b1) @(posedge ref_clk);
		ns = 0;
		do begin
			@(posedge ref_clk);
			ns += int'(stb === 1'b1);
		end while (adv !== 1'b1);
		chk(32'(ns), 32'h3);
		test_done();
	end
endmodule : tb
